//--- ptm_pkg.sv
// Shared constants, types and states for the 10 Mbps PHY timing block
package ptm_pkg;

    // Clock and bit timing
    localparam int CLK_NS        = 5;
    localparam int BIT_NS        = 100;
    localparam int BIT_CYC       = BIT_NS / CLK_NS;
    localparam int BCW           = 5;
    localparam int BTW           = 23;

    // Receive side, in bit times; the carrier tail in clock cycles
    localparam int RX_CRS_ON_BT  = 4;
    localparam int RX_DV_ON_BT   = 12;
    localparam int RX_QUIET_BT   = 7;
    localparam int COL_ON_BT     = 2;
    localparam int CRS_TAIL_NS   = 40;
    localparam int CRS_TAIL_CYC  = (CRS_TAIL_NS + CLK_NS - 1) / CLK_NS;

    // Transmit side
    localparam int TX_CRS_ON_BT  = 2;
    localparam int TX_DELAY_BT   = 71;
    localparam int NIB_LAST      = 3;

    // Heartbeat
    localparam int SQE_DELAY_NS  = 1000;
    localparam int SQE_DELAY_CYC = SQE_DELAY_NS / CLK_NS;
    localparam int SQE_WIDTH_NS  = 1000;
    localparam int SQE_WIDTH_CYC = SQE_WIDTH_NS / CLK_NS;

    // Jabber, in bit times
    localparam int JAB_MS        = 50;
    localparam int JAB_BT_DEF    = JAB_MS * 1000000 / BIT_NS;
    localparam int UNJAB_MS      = 500;
    localparam int UNJAB_BT_DEF  = UNJAB_MS * 1000000 / BIT_NS;

    // Fast link pulses, in bit times
    localparam int FLP_CLK_NS    = 125000;
    localparam int FLP_CLK_BT_DEF  = FLP_CLK_NS / BIT_NS;
    localparam int FLP_DATA_NS   = 62500;
    localparam int FLP_DATA_BT_DEF = FLP_DATA_NS / BIT_NS;
    localparam int FLP_BURST_MS  = 12;
    localparam int FLP_BURST_BT_DEF = FLP_BURST_MS * 1000000 / BIT_NS;
    localparam int FLP_SLOTS     = 17;

    // Recovery after reset
    localparam int READY_US      = 250;
    localparam int READY_CYC_DEF = READY_US * 1000 / CLK_NS;
    localparam int READY_W       = 16;

    typedef struct packed {
        logic       en;
        logic [3:0] d;
    } ptm_mii_tx_s;

    typedef struct packed {
        logic       crs;
        logic       col;
        logic       dv;
        logic       er;
        logic [3:0] d;
    } ptm_mii_rx_s;

    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_SENSE = 4'b0010,
        RX_FRAME = 4'b0100,
        RX_TAIL  = 4'b1000
    } ptm_rx_e;

    typedef enum logic [2:0] {
        JB_OK    = 3'b001,
        JB_CUT   = 3'b010,
        JB_UNJAB = 3'b100
    } ptm_jab_e;

    typedef enum logic [2:0] {
        SQ_IDLE  = 3'b001,
        SQ_WAIT  = 3'b010,
        SQ_PULSE = 3'b100
    } ptm_sqe_e;

endpackage

//--- ptm_phy_timing.sv
// 10 Mbps PHY timing core: receive sense, transmit echo, jabber, heartbeat, link pulses
`timescale 1ns/10ps
module ptm_phy_timing #(
    parameter int unsigned JAB_BT       = ptm_pkg::JAB_BT_DEF,
    parameter int unsigned UNJAB_BT     = ptm_pkg::UNJAB_BT_DEF,
    parameter int unsigned FLP_CLK_BT   = ptm_pkg::FLP_CLK_BT_DEF,
    parameter int unsigned FLP_DATA_BT  = ptm_pkg::FLP_DATA_BT_DEF,
    parameter int unsigned FLP_BURST_BT = ptm_pkg::FLP_BURST_BT_DEF,
    parameter int unsigned READY_CYC    = ptm_pkg::READY_CYC_DEF
) (
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    input  wire logic                 clk_link,
    input  wire ptm_pkg::ptm_mii_tx_s mac_tx,
    output ptm_pkg::ptm_mii_rx_s      mac_rx,
    output logic                      nibble_strobe,
    input  wire logic                 full_duplex,
    input  wire logic                 an_enable,
    input  wire logic [15:0]          an_code_word,
    input  wire logic [1:0]           line_receive_pair_pos_neg,
    output logic                      line_transmit_pair,
    output logic                      line_transmit_enable,
    output logic                      jabber,
    output logic                      mgmt_ready
);
    import ptm_pkg::*;

    logic [READY_W-1:0]     ready_cnt;
    logic [BCW-1:0]         bit_cnt;
    logic [1:0]             nib_cnt;
    logic                   bit_tick;
    logic [1:0]             rx_s1;
    logic [1:0]             rx_s2;
    logic                   rx_act;
    logic                   rx_bit;
    logic                   rx_bad;
    ptm_rx_e                rx_state;
    logic [4:0]             rx_bits;
    logic [3:0]             rx_quiet;
    logic [3:0]             rx_tail;
    logic                   rx_dly;
    logic [3:0]             rx_sh;
    logic                   rx_err_acc;
    logic                   crs_rx;
    logic                   col_rx;
    logic                   rx_dv;
    logic                   rx_er;
    logic [3:0]             rxd;
    logic                   tx_en_q;
    logic                   tx_on;
    logic                   tx_on_d;
    logic [1:0]             tx_crs_cnt;
    logic                   crs_tx;
    logic [3:0]             tx_sh;
    logic                   tx_sh_en;
    logic [TX_DELAY_BT-1:0] dl_d;
    logic [TX_DELAY_BT-1:0] dl_en;
    ptm_jab_e               jab_state;
    logic [BTW-1:0]         jab_cnt;
    ptm_sqe_e               sqe_state;
    logic [7:0]             sqe_cnt;
    logic                   col_sqe;
    logic [BTW-1:0]         burst_bt;
    logic [BTW-1:0]         slot_bt;
    logic [4:0]             slot_idx;
    logic                   in_burst;
    logic                   flp_pulse;
    logic                   line_busy;
    logic                   ln_d;
    logic                   ln_en;
    logic                   ln_tgl;
    logic [1:0]             lk_rst;
    logic [2:0]             lk_sync;

    // Hold the core quiet until the recovery time has run out
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ready_cnt  <= '0;
            mgmt_ready <= 1'b0;
        end else if (!mgmt_ready) begin
            ready_cnt <= ready_cnt + 1'b1;
            if (ready_cnt == READY_W'(READY_CYC - 1)) begin
                mgmt_ready <= 1'b1;
            end
        end
    end

    // Bit time and nibble timebase
    assign bit_tick = (bit_cnt == BCW'(BIT_CYC - 1));

    always_ff @(posedge clk_sys) begin
        if (!rst_n || !mgmt_ready) begin
            bit_cnt       <= '0;
            nib_cnt       <= '0;
            nibble_strobe <= 1'b0;
        end else begin
            bit_cnt       <= bit_tick ? '0 : bit_cnt + 1'b1;
            nibble_strobe <= bit_tick && (nib_cnt == 2'(NIB_LAST));
            if (bit_tick) begin
                nib_cnt <= nib_cnt + 1'b1;
            end
        end
    end

    // Line pins come from another domain
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rx_s1 <= '0;
            rx_s2 <= '0;
        end else begin
            rx_s1 <= line_receive_pair_pos_neg;
            rx_s2 <= rx_s1;
        end
    end

    assign rx_act = rx_s2[1] ^ rx_s2[0];
    assign rx_bit = rx_s2[1];
    assign rx_bad = &rx_s2;

    // Receive framing: sense, data, quiet tail
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !mgmt_ready) begin
            rx_state <= RX_IDLE;
            rx_bits  <= '0;
            rx_quiet <= '0;
            rx_tail  <= '0;
            crs_rx   <= 1'b0;
            rx_dv    <= 1'b0;
        end else begin
            unique case (rx_state)
                RX_IDLE: begin
                    rx_bits  <= '0;
                    rx_quiet <= '0;
                    if (bit_tick && rx_act) begin
                        rx_state <= RX_SENSE;
                        rx_bits  <= 5'd1;
                    end
                end
                RX_SENSE, RX_FRAME: begin
                    if (bit_tick) begin
                        rx_quiet <= rx_act ? '0 : rx_quiet + 1'b1;
                        if (rx_bits != '1) begin
                            rx_bits <= rx_bits + 1'b1;
                        end
                        if (rx_bits == 5'(RX_CRS_ON_BT - 1)) begin
                            crs_rx   <= 1'b1;
                            rx_state <= RX_FRAME;
                        end
                        if (!rx_act && rx_quiet == 4'(RX_QUIET_BT - 1)) begin
                            rx_dv    <= 1'b0;
                            rx_tail  <= '0;
                            rx_state <= RX_TAIL;
                        end
                    end else if (nibble_strobe && rx_state == RX_FRAME
                                 && rx_bits >= 5'(RX_DV_ON_BT)) begin
                        rx_dv <= 1'b1;
                    end
                end
                RX_TAIL: begin
                    rx_tail <= rx_tail + 1'b1;
                    if (rx_tail == 4'(CRS_TAIL_CYC - 1)) begin
                        crs_rx   <= 1'b0;
                        rx_state <= RX_IDLE;
                    end
                end
            endcase
        end
    end

    // Bit assembly: one stage of delay, then LSB-first nibble
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !mgmt_ready) begin
            rx_dly     <= 1'b0;
            rx_sh      <= '0;
            rx_err_acc <= 1'b0;
            rxd        <= '0;
            rx_er      <= 1'b0;
        end else begin
            if (bit_tick) begin
                rx_dly <= rx_bit;
                rx_sh  <= {rx_dly, rx_sh[3:1]};
                if (rx_bad && rx_state != RX_IDLE) begin
                    rx_err_acc <= 1'b1;
                end
            end
            if (rx_state == RX_TAIL || rx_state == RX_IDLE) begin
                rxd        <= '0;
                rx_er      <= 1'b0;
                rx_err_acc <= 1'b0;
            end else if (nibble_strobe) begin
                rxd        <= rx_sh;
                rx_er      <= rx_err_acc;
                rx_err_acc <= 1'b0;
            end
        end
    end

    // Collision from receive activity while transmitting
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !mgmt_ready || full_duplex) begin
            col_rx <= 1'b0;
        end else if (rx_state == RX_IDLE || rx_state == RX_TAIL) begin
            col_rx <= 1'b0;
        end else if (bit_tick && tx_on && rx_bits >= 5'(COL_ON_BT)) begin
            col_rx <= 1'b1;
        end
    end

    // Transmit enable sampling and jabber guard
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !mgmt_ready) begin
            tx_en_q <= 1'b0;
        end else if (nibble_strobe) begin
            tx_en_q <= mac_tx.en;
        end
    end

    assign tx_on  = tx_en_q && (jab_state == JB_OK);
    assign jabber = (jab_state != JB_OK);

    always_ff @(posedge clk_sys) begin
        if (!rst_n || !mgmt_ready) begin
            jab_state <= JB_OK;
            jab_cnt   <= '0;
        end else if (bit_tick) begin
            unique case (jab_state)
                JB_OK: begin
                    jab_cnt <= tx_en_q ? jab_cnt + 1'b1 : '0;
                    if (tx_en_q && jab_cnt == BTW'(JAB_BT - 1)) begin
                        jab_state <= JB_CUT;
                        jab_cnt   <= '0;
                    end
                end
                JB_CUT: begin
                    if (!tx_en_q) begin
                        jab_state <= JB_UNJAB;
                    end
                end
                JB_UNJAB: begin
                    // A new attempt during the hold-off restarts it
                    jab_cnt <= tx_en_q ? '0 : jab_cnt + 1'b1;
                    if (!tx_en_q && jab_cnt == BTW'(UNJAB_BT - 1)) begin
                        jab_state <= JB_OK;
                        jab_cnt   <= '0;
                    end
                end
            endcase
        end
    end

    // Carrier echo of our own transmission, half duplex only
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !mgmt_ready || full_duplex) begin
            tx_crs_cnt <= '0;
            crs_tx     <= 1'b0;
        end else if (bit_tick) begin
            if (!tx_on) begin
                tx_crs_cnt <= '0;
                crs_tx     <= 1'b0;
            end else begin
                if (tx_crs_cnt != '1) begin
                    tx_crs_cnt <= tx_crs_cnt + 1'b1;
                end
                if (tx_crs_cnt == 2'(TX_CRS_ON_BT - 1)) begin
                    crs_tx <= 1'b1;
                end
            end
        end
    end

    // Serialiser feeding a bit delay line; the line itself holds the latency
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !mgmt_ready) begin
            tx_sh    <= '0;
            tx_sh_en <= 1'b0;
            dl_d     <= '0;
            dl_en    <= '0;
        end else begin
            if (nibble_strobe) begin
                tx_sh    <= mac_tx.d;
                tx_sh_en <= mac_tx.en && (jab_state == JB_OK);
            end else if (bit_tick) begin
                tx_sh <= {1'b0, tx_sh[3:1]};
            end
            if (bit_tick) begin
                dl_d  <= {dl_d[TX_DELAY_BT-2:0], tx_sh[0]};
                dl_en <= {dl_en[TX_DELAY_BT-2:0], tx_sh_en && tx_on};
            end
        end
    end

    // Heartbeat after each transmission that ends without a jabber cut, in half duplex
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !mgmt_ready) begin
            tx_on_d   <= 1'b0;
            sqe_state <= SQ_IDLE;
            sqe_cnt   <= '0;
        end else begin
            tx_on_d <= tx_on;
            unique case (sqe_state)
                SQ_IDLE: begin
                    sqe_cnt <= '0;
                    if (tx_on_d && !tx_on && !jabber && !full_duplex) begin
                        sqe_state <= SQ_WAIT;
                    end
                end
                SQ_WAIT: begin
                    sqe_cnt <= sqe_cnt + 1'b1;
                    if (sqe_cnt == 8'(SQE_DELAY_CYC - 1)) begin
                        sqe_cnt   <= '0;
                        sqe_state <= SQ_PULSE;
                    end
                end
                SQ_PULSE: begin
                    sqe_cnt <= sqe_cnt + 1'b1;
                    if (sqe_cnt == 8'(SQE_WIDTH_CYC - 1)) begin
                        sqe_state <= SQ_IDLE;
                    end
                end
            endcase
        end
    end

    assign col_sqe = (sqe_state == SQ_PULSE);

    // Fast link pulse bursts, counted in bit times
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !mgmt_ready || !an_enable) begin
            burst_bt <= '0;
            slot_bt  <= '0;
            slot_idx <= '0;
            in_burst <= 1'b0;
        end else if (bit_tick) begin
            burst_bt <= (burst_bt == BTW'(FLP_BURST_BT - 1)) ? '0 : burst_bt + 1'b1;
            if (burst_bt == '0) begin
                in_burst <= 1'b1;
                slot_bt  <= '0;
                slot_idx <= '0;
            end else if (in_burst) begin
                if (slot_bt == BTW'(FLP_CLK_BT - 1)) begin
                    slot_bt  <= '0;
                    slot_idx <= slot_idx + 1'b1;
                    if (slot_idx == 5'(FLP_SLOTS - 1)) begin
                        in_burst <= 1'b0;
                    end
                end else begin
                    slot_bt <= slot_bt + 1'b1;
                end
            end
        end
    end

    // Clock pulse opens each slot; data pulse only for a one bit
    assign flp_pulse = in_burst && slot_idx < 5'(FLP_SLOTS) && (slot_bt == '0
                       || (slot_bt == BTW'(FLP_DATA_BT) && slot_idx < 5'(FLP_SLOTS - 1)
                           && an_code_word[slot_idx[3:0]]));

    // Link pulses are suppressed while frame data is in flight
    assign line_busy = tx_on || (|dl_en);

    // Each bit crosses to the link domain with a toggle; data is stable for a bit time
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ln_d   <= 1'b0;
            ln_en  <= 1'b0;
            ln_tgl <= 1'b0;
        end else if (bit_tick) begin
            ln_en  <= (dl_en[TX_DELAY_BT-1] && !jabber) || (flp_pulse && !line_busy);
            ln_d   <= dl_en[TX_DELAY_BT-1] ? dl_d[TX_DELAY_BT-1] : flp_pulse;
            ln_tgl <= ~ln_tgl;
        end
    end

    always_ff @(posedge clk_link) begin
        lk_rst <= {lk_rst[0], rst_n};
    end

    always_ff @(posedge clk_link) begin
        if (!lk_rst[1]) begin
            lk_sync              <= '0;
            line_transmit_pair   <= 1'b0;
            line_transmit_enable <= 1'b0;
        end else begin
            lk_sync <= {lk_sync[1:0], ln_tgl};
            if (lk_sync[2] ^ lk_sync[1]) begin
                line_transmit_pair   <= ln_d && ln_en;
                line_transmit_enable <= ln_en;
            end
        end
    end

    assign mac_rx = '{crs: crs_rx | crs_tx,
                      col: col_rx | col_sqe,
                      dv:  rx_dv,
                      er:  rx_er,
                      d:   rxd};

endmodule // ptm_phy_timing

//--- ptm_phy_timing_sva.sv
// Concurrent timing checks on the ports of the 10 Mbps PHY timing core
`timescale 1ns/10ps
module ptm_phy_timing_sva #(
    parameter int unsigned JAB_BT    = 50,
    parameter int unsigned UNJAB_BT  = 100,
    parameter int unsigned READY_CYC = 20
) (
    input wire logic                 clk_sys,
    input wire logic                 rst_n,
    input wire ptm_pkg::ptm_mii_tx_s mac_tx,
    input wire ptm_pkg::ptm_mii_rx_s mac_rx,
    input wire logic [1:0]           line_receive_pair_pos_neg,
    input wire logic                 jabber,
    input wire logic                 mgmt_ready
);
    import ptm_pkg::*;
    logic [15:0] act_cnt, quiet_cnt, on_cnt, off_cnt, col_len, crs_len, rel_cnt;
    wire         line_act = |line_receive_pair_pos_neg;

    function automatic logic [15:0] sat(input logic [15:0] c);
        return c + {15'h0, c != 16'hffff};
    endfunction

    // Saturating run lengths, so a long idle never wraps back into a legal window
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            {act_cnt, quiet_cnt, on_cnt, off_cnt, col_len, crs_len, rel_cnt} <= '0;
        end else begin
            act_cnt   <= line_act ? sat(act_cnt) : 16'h0;
            quiet_cnt <= line_act ? 16'h0 : sat(quiet_cnt);
            on_cnt    <= mac_tx.en ? sat(on_cnt) : 16'h0;
            off_cnt   <= mac_tx.en ? 16'h0 : sat(off_cnt);
            col_len   <= mac_rx.col ? sat(col_len) : 16'h0;
            crs_len   <= mac_rx.crs ? sat(crs_len) : 16'h0;
            rel_cnt   <= sat(rel_cnt);
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    dv_after_crs_a : assert property ($rose(mac_rx.dv) |-> crs_len >= 100 && crs_len <= 640)
        else $error("receive valid rose outside its carrier window");
    crs_tail_a : assert property ($fell(mac_rx.dv) |-> mac_rx.crs[*6] ##[1:5] !mac_rx.crs)
        else $error("carrier tail after receive valid out of range");
    crs_quiet_a : assert property ($fell(mac_rx.dv) |-> quiet_cnt >= 112 && quiet_cnt <= 192)
        else $error("receive end not tied to line quiet time");
    crs_rise_a : assert property ($rose(line_act) && !mac_rx.crs |->
        !mac_rx.crs[*8] ##[33:553] mac_rx.crs)
        else $error("carrier did not rise in its window after line activity");
    col_rise_a : assert property ($rose(mac_rx.col) && act_cnt != 0 |->
        act_cnt >= 20 && act_cnt <= 620)
        else $error("collision rose outside its window");
    col_fall_a : assert property ($fell(mac_rx.col) && quiet_cnt != 0 && quiet_cnt < 300 |->
        quiet_cnt >= 100 && quiet_cnt <= 200)
        else $error("collision fell outside its quiet window");
    sqe_delay_a : assert property ($rose(mac_rx.col) && act_cnt == 0 |->
        off_cnt >= 130 && off_cnt <= 320)
        else $error("heartbeat start delay out of range");
    sqe_width_a : assert property ($fell(mac_rx.col) && quiet_cnt >= 300 |->
        col_len >= 100 && col_len <= 300)
        else $error("heartbeat width out of range");
    jab_cut_a : assert property ($rose(jabber) |-> on_cnt >= JAB_BT * BIT_CYC - 100 &&
        on_cnt <= JAB_BT * BIT_CYC + 100)
        else $error("jabber cut time out of range");
    jab_release_a : assert property ($fell(jabber) |-> !mac_tx.en &&
        off_cnt >= UNJAB_BT * BIT_CYC - 100 && off_cnt <= UNJAB_BT * BIT_CYC + 100)
        else $error("unjab time out of range");
    ready_time_a : assert property ($rose(mgmt_ready) |->
        rel_cnt >= READY_CYC - 2 && rel_cnt <= READY_CYC + 2)
        else $error("ready after reset at wrong time");
endmodule // ptm_phy_timing_sva

bind ptm_phy_timing ptm_phy_timing_sva #(
    .JAB_BT(JAB_BT), .UNJAB_BT(UNJAB_BT), .READY_CYC(READY_CYC)
) i_sva (
    .clk_sys, .rst_n, .mac_tx, .mac_rx, .line_receive_pair_pos_neg, .jabber, .mgmt_ready
);

//--- ptm_mac_model.sv
// MAC transmit model: hands the PHY one whole nibble per strobe
`timescale 1ns/10ps
module ptm_mac_model (
    input  wire logic            clk_sys,
    input  wire logic            rst_n,
    input  wire logic            nibble_strobe,
    input  wire logic            mgmt_ready,
    input  wire logic            start,
    input  wire logic [7:0]      nibs,
    output ptm_pkg::ptm_mii_tx_s mac_tx,
    output logic                 busy
);
    import ptm_pkg::*;
    logic [7:0] left;
    logic [3:0] nib;

    assign busy = (left != 8'h0) || mac_tx.en;
    initial mac_tx = '0;
    // Changes land half a cycle before the strobe edge that samples them
    always @(negedge clk_sys) begin
        if (!rst_n) begin
            left = 8'h0;
            mac_tx = '0;
        end else begin
            // No traffic before the PHY reports its recovery done
            if (start && mgmt_ready && !busy) begin
                left = nibs;
                nib = 4'hd;
            end
            if (nibble_strobe) begin
                mac_tx.en = (left != 8'h0);
                // Idle data lines alternate between the inverse of the last nibble and the last nibble
                mac_tx.d = (left != 8'h0) ? nib : ~mac_tx.d;
                nib = nib + 4'h1;
                left = (left != 8'h0) ? left - 8'h1 : 8'h0;
            end
        end
    end
endmodule // ptm_mac_model

//--- ptm_phy_timing_test.sv
// Self-checking bench for the 10 Mbps PHY timing core
`timescale 1ns/10ps
module ptm_phy_timing_test;
    import ptm_pkg::*;
    localparam logic [15:0] CODE = 16'ha5c3;
    logic        clk_sys, clk_link, rst_n, full_duplex, an_enable, start, busy, jabber;
    logic        nibble_strobe, line_transmit_pair, line_transmit_enable, mgmt_ready;
    logic        seen_dv, seen_er, seen_col, bad_d;
    logic [1:0]  line_receive_pair_pos_neg;
    logic [7:0]  nibs;
    ptm_mii_tx_s mac_tx;
    ptm_mii_rx_s mac_rx;
    int          error_cnt, tests_run;

    ptm_phy_timing #(.JAB_BT(50), .UNJAB_BT(100), .FLP_CLK_BT(20), .FLP_DATA_BT(10),
        .FLP_BURST_BT(500)) i_dut (
        .clk_sys, .rst_n, .clk_link, .mac_tx, .mac_rx, .nibble_strobe, .full_duplex,
        .an_enable, .an_code_word(CODE), .line_receive_pair_pos_neg, .line_transmit_pair,
        .line_transmit_enable, .jabber, .mgmt_ready);
    ptm_mac_model i_mac (.clk_sys, .rst_n, .nibble_strobe, .mgmt_ready, .start, .nibs,
        .mac_tx, .busy);

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        clk_link = 1'b0;
        #7;
        forever #16 clk_link = ~clk_link;
    end
    always @(posedge clk_sys) begin
        if (mac_rx.dv === 1'b1 && |line_receive_pair_pos_neg && mac_rx.d !== 4'hf) bad_d = 1'b1;
        if (mac_rx.dv) seen_dv = 1'b1;
        if (mac_rx.er !== 1'b0) seen_er = 1'b1;
        if (mac_rx.col !== 1'b0) seen_col = 1'b1;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("Checks made %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic send(input logic [7:0] n);
        @(negedge clk_sys);
        nibs = n;
        start = 1'b1;
        wait (busy);
        @(negedge clk_sys);
        start = 1'b0;
    endtask

    // Each line bit is held one bit time; 11 marks an invalid symbol
    task automatic line_frame(input int nbits, input int bad_at);
        for (int i = 0; i < nbits; i++) begin
            @(negedge clk_sys);
            line_receive_pair_pos_neg = (i == bad_at) ? 2'b11 : 2'b10;
            repeat (BIT_CYC - 1) @(negedge clk_sys);
        end
        @(negedge clk_sys);
        line_receive_pair_pos_neg = 2'b00;
    endtask

    task automatic test_rx();
        {seen_dv, seen_er, bad_d} = 3'b000;
        line_frame(32, -1);
        repeat (300) @(negedge clk_sys);
        check("rx valid", seen_dv, 1);
        check("rx nibble", bad_d, 0);
        check("rx carrier end", mac_rx.crs, 0);
        check("rx clean", seen_er, 0);
        line_frame(32, 20);
        repeat (300) @(negedge clk_sys);
        check("rx error", seen_er, 1);
        $display("receive test done");
    endtask

    task automatic test_tx(input logic fd);
        realtime t0;
        int n;
        logic [3:0] bits;
        @(negedge clk_sys);
        full_duplex = fd;
        seen_col = 1'b0;
        send(8'd8);
        @(posedge clk_sys iff (nibble_strobe && mac_tx.en));
        t0 = $realtime;
        for (n = 0; n < 100 && mac_rx.crs !== 1'b1; n++) @(posedge clk_sys);
        check("echo rise", fd ? n == 100 : (n >= 35 && n <= 45), 1);
        @(posedge clk_sys iff (nibble_strobe && !mac_tx.en));
        for (n = 0; n < 100 && mac_rx.crs !== 1'b0; n++) @(posedge clk_sys);
        check("echo fall", fd ? n == 0 : (n >= 15 && n <= 25), 1);
        for (n = 0; n < 2000 && line_transmit_enable !== 1'b1; n++) @(posedge clk_sys);
        check("tx latency", $realtime - t0 >= 7000 && $realtime - t0 <= 7600, 1);
        #50;
        for (int i = 0; i < 4; i++) begin
            bits[i] = line_transmit_pair;
            #100;
        end
        check("tx bit order", bits, 4'hd);
        repeat (100) @(negedge clk_sys);
        check("heartbeat", seen_col, !fd);
        $display("transmit test done, full duplex %0d", fd);
    endtask

    task automatic test_col();
        @(negedge clk_sys);
        full_duplex = 1'b0;
        seen_col = 1'b0;
        send(8'd6);
        repeat (100) @(negedge clk_sys);
        line_frame(40, -1);
        repeat (300) @(negedge clk_sys);
        check("collision", seen_col, 1);
        check("collision end", mac_rx.col, 0);
        $display("collision test done");
    endtask

    task automatic test_jab();
        send(8'd70);
        repeat (3000) @(negedge clk_sys);
        check("jabber on", jabber, 1);
        check("jabber echo", mac_rx.crs, 0);
        wait (!busy);
        repeat (1500) @(negedge clk_sys);
        check("jabber hold", jabber, 1);
        repeat (700) @(negedge clk_sys);
        check("jabber free", jabber, 0);
        $display("jabber test done");
    endtask

    task automatic test_flp();
        int hi;
        int edges;
        logic prev;
        @(negedge clk_sys);
        an_enable = 1'b1;
        {hi, edges, prev} = '0;
        repeat (200) @(negedge clk_sys);
        // One burst period of samples holds exactly one burst's pulses
        repeat (10000) begin
            @(posedge clk_sys);
            if (line_transmit_enable && !prev) edges++;
            if (line_transmit_enable) hi++;
            prev = line_transmit_enable;
        end
        check("flp pulses", edges, 17 + $countones(CODE));
        check("flp width", hi >= edges * 18 && hi <= edges * 22, 1);
        an_enable = 1'b0;
        $display("link pulse test done");
    endtask

    initial begin
        {rst_n, full_duplex, an_enable, start, nibs} = '0;
        {seen_dv, seen_er, seen_col, bad_d} = '0;
        line_receive_pair_pos_neg = 2'b00;
        {error_cnt, tests_run} = '0;
        repeat (10) @(negedge clk_sys);
        rst_n = 1'b1;
        for (int n = 0; n < 60000 && mgmt_ready !== 1'b1; n++) @(negedge clk_sys);
        check("ready", mgmt_ready, 1);
        test_rx();
        test_tx(1'b0);
        test_tx(1'b1);
        test_col();
        test_jab();
        test_flp();
        close_out();
    end

    initial begin
        #450000;
        error_cnt++;
        $display("BAD watchdog expected finish seen timeout");
        close_out();
    end
endmodule // ptm_phy_timing_test
